// ### rtl/meter_cmd_regs.vh
// Register offsets, field positions, codes and reset values of the command, control and configuration block.
`ifndef METER_CMD_REGS_VH
`define METER_CMD_REGS_VH

// ==========================================================================
// Word indices of the three registers kept by this block.
`define TASK_COMMAND_WORD_IDX          8'h00
`define ACCUMULATOR_CLEAR_CONTROL_IDX  8'h24
`define SENSOR_ROUTING_CONFIG_IDX      8'h25

// ==========================================================================
// Register geometry.
`define REG_WIDTH                      24
`define REG_AREA_WORDS                 256
`define BYTES_PER_WORD                 8'h03

// ==========================================================================
// Reset values.
`define TASK_COMMAND_WORD_RST          24'h000000
`define ACCUMULATOR_CLEAR_CONTROL_RST  24'h000000
`define SENSOR_ROUTING_CONFIG_RST      24'h000000

// ==========================================================================
// Command codes and fields.
`define CMD_OP_MSB                     23
`define CMD_OP_LSB                     16
`define CMD_OP_GENERAL                 8'h00
`define CMD_OP_CALIBRATE               8'hca
`define CMD_OP_SOFT_RESET              8'hbd
`define CMD_ACCESS_MSB                 23
`define CMD_ACCESS_LSB                 12
`define CMD_ACCESS_CODE                12'hacc
`define CMD_FLASH_OP_MSB               11
`define CMD_FLASH_OP_LSB               8
`define CMD_FLASH_ERASE_SEC0           4'h0
`define CMD_FLASH_ERASE_SEC1           4'h1
`define CMD_FLASH_SAVE                 4'h2
`define CMD_LINE_LOCK_BIT              5
`define CMD_TEMP_COMP_BIT              4
`define CMD_CAL_SEL_MSB                14
`define CMD_CAL_SEL_LSB                10
`define CMD_CAL_OFFSET_BIT             9

// ==========================================================================
// Control and configuration fields.
`define CTRL_CLEAR_ACCUM_BIT           2
`define CTRL_CLEAR_COUNT_BIT           1
`define CTRL_MINMAX_BIT                0
`define CTRL_USED_MASK                 24'h000007
`define CFG_REF_MSB                    23
`define CFG_REF_LSB                    22
`define CFG_USED_MASK                  24'hcfffff
`define CFG_MULT_FIELDS                10

`endif

// ### rtl/reg_addr_map.v
// Translates a host address, byte or word style, into a register word index.
`timescale 1ns/1ps
`default_nettype none
`include "meter_cmd_regs.vh"

module reg_addr_map
(
  input  wire [7:0] host_addr,
  input  wire       byte_mode,
  output reg  [7:0] word_index,
  output reg        addr_ok
);

  // ========================================================================
  // Address translation
  // Byte addresses step by three per 24-bit word; only word-aligned ones map.
  always @*
  begin
    if (byte_mode)
    begin
      word_index = host_addr / `BYTES_PER_WORD;
      addr_ok    = ((host_addr % `BYTES_PER_WORD) == 8'h00);
    end
    else
    begin
      word_index = host_addr;
      addr_ok    = 1'b1;
    end
  end

endmodule // reg_addr_map

`default_nettype wire

// ### rtl/mult_field_decode.v
// Decodes one 2-bit sensor multiplier field into a small signed weight.
`timescale 1ns/1ps
`default_nettype none

module mult_field_decode
(
  input  wire [1:0] field,
  output reg  [2:0] weight
);

  // ========================================================================
  // Field decode
  // Weight is three-bit two's complement so that both minus one and two fit.
  always @*
  begin
    case (field)
      2'b00:   weight = 3'h7;
      2'b01:   weight = 3'h0;
      2'b10:   weight = 3'h1;
      default: weight = 3'h2;
    endcase
  end

endmodule // mult_field_decode

`default_nettype wire

// ### rtl/meter_command_control_config.v
// Command interpreter with control and configuration registers of the energy measurement processor.
// Function
// - Decode command word by its top byte.
// - Top byte zero applies general settings.
// - Bit 5 locks sample period to line.
// - Bit 4 enables die temperature gain compensation.
// - Calibrate code starts calibration of selected channels.
// - Bits 14 to 10 select calibration channels.
// - Bit 9 chooses offset or gain calibration.
// - On finish clear opcode and successful channel bits.
// - Failed gain channels keep their select bit.
// - Offset calibration keeps channel bits until cleared.
// - Access code with two saves defaults to flash.
// - Access code with zero/one erases flash section.
// - Control bits clear energy and restart min/max.
// - Config bits 23:22 choose zero-crossing reference.
// - Config low bits form sensor multiplier fields.
// - Multiplier fields decode to -1, 0, 1, 2.
// - 24-bit words, byte or word addressed.
// - Integer registers hold unsigned 24-bit values.
// - Fixed-point values are two's complement.
`timescale 1ns/1ps
`default_nettype none
`include "meter_cmd_regs.vh"

module meter_command_control_config
(
  // Clock and synchronous reset.
  input  wire        clk_sys,
  input  wire        rst_b,
  // Register port used by the serial host interface.
  input  wire        uart_byte_mode,
  input  wire        reg_wr,
  input  wire        reg_rd,
  input  wire [7:0]  reg_addr,
  input  wire [23:0] reg_wdata,
  output reg  [23:0] reg_rdata,
  output reg         reg_rvalid,
  // General settings.
  output reg         line_lock_enable,
  output reg         die_temp_comp_enable,
  // Calibration engine handshake.
  output reg         cal_start,
  output reg  [4:0]  cal_channel_sel,
  output reg         cal_offset_mode,
  output wire        cal_busy,
  input  wire        cal_done,
  input  wire [4:0]  cal_fail,
  // Flash and reset requests.
  output reg         flash_save_req,
  output reg         flash_erase_req,
  output reg         flash_erase_section,
  output reg         soft_reset_req,
  // Measurement clear requests.
  output reg         energy_accum_clear,
  output reg         energy_count_clear,
  output reg         minmax_restart,
  // Sensor routing.
  output reg  [1:0]  zc_ref_select,
  output wire [29:0] mult_weights
);

  // ========================================================================
  // Local states and declarations
  // ========================================================================
  localparam [1:0] ST_IDLE  = 2'b00;  // No calibration running.
  localparam [1:0] ST_START = 2'b01;  // Start pulse issued to the engine.
  localparam [1:0] ST_WAIT  = 2'b10;  // Waiting for the engine to finish.

  reg  [23:0] task_command_word;          // Command register contents.
  reg  [23:0] accumulator_clear_control;  // Control register contents.
  reg  [23:0] sensor_routing_config;      // Configuration register contents.
  reg  [1:0]  cal_state;                  // Calibration sequencer state.
  reg  [1:0]  next_cal_state;             // Next calibration state.
  wire [7:0]  word_index;                 // Word index after translation.
  wire        addr_ok;                    // Address maps onto a word.
  wire        wr_cmd;                     // Write strobe for the command word.
  wire        wr_ctrl;                    // Write strobe for the control word.
  wire        wr_cfg;                     // Write strobe for the config word.
  wire [7:0]  cmd_op;                     // Top byte of the written command.
  wire        is_general;                 // Written command is general settings.
  wire        is_calibrate;               // Written command is a calibration.
  wire        is_soft_reset;              // Written command is software reset.
  wire        is_access;                  // Written command is a flash access.
  wire [3:0]  flash_op;                   // Flash access sub-operation.
  wire        flash_op_valid;             // Flash sub-operation is defined.
  wire        cmd_accepted;               // Command is known and not refused.
  wire [4:0]  cal_keep;                   // Channel bits left set at finish.

  // ========================================================================
  // Address translation
  // Byte addresses apply in UART mode, word addresses otherwise.
  reg_addr_map u_addr_map
  (
    .host_addr  (reg_addr),
    .byte_mode  (uart_byte_mode),
    .word_index (word_index),
    .addr_ok    (addr_ok)
  );

  // Write strobes; any other index is simply not stored.
  assign wr_cmd  = reg_wr && addr_ok && (word_index == `TASK_COMMAND_WORD_IDX);
  assign wr_ctrl = reg_wr && addr_ok && (word_index == `ACCUMULATOR_CLEAR_CONTROL_IDX);
  assign wr_cfg  = reg_wr && addr_ok && (word_index == `SENSOR_ROUTING_CONFIG_IDX);

  // ========================================================================
  // Command decode
  // The top byte selects the task; flash access uses a twelve-bit code.
  assign cmd_op         = reg_wdata[`CMD_OP_MSB:`CMD_OP_LSB];
  assign is_general     = (cmd_op == `CMD_OP_GENERAL);
  assign is_calibrate   = (cmd_op == `CMD_OP_CALIBRATE);
  assign is_soft_reset  = (cmd_op == `CMD_OP_SOFT_RESET);
  assign is_access      = (reg_wdata[`CMD_ACCESS_MSB:`CMD_ACCESS_LSB] == `CMD_ACCESS_CODE);
  assign flash_op       = reg_wdata[`CMD_FLASH_OP_MSB:`CMD_FLASH_OP_LSB];
  assign flash_op_valid = (flash_op == `CMD_FLASH_SAVE) ||
                          (flash_op == `CMD_FLASH_ERASE_SEC0) ||
                          (flash_op == `CMD_FLASH_ERASE_SEC1);

  // Unknown codes and any command while calibrating are dropped whole.
  assign cmd_accepted = wr_cmd && (cal_state == ST_IDLE) &&
                        (is_general || is_calibrate || is_soft_reset ||
                         (is_access && flash_op_valid));

  assign cal_busy = (cal_state != ST_IDLE);

  // Gain runs keep failed channels; offset runs keep every selected channel.
  assign cal_keep = cal_offset_mode ? cal_channel_sel : (cal_channel_sel & cal_fail);

  // ========================================================================
  // Calibration sequencer next state
  // One start pulse, then wait for the engine's done pulse.
  always @*
  begin
    case (cal_state)
      ST_IDLE:
      begin
        if (cmd_accepted && is_calibrate)
        begin
          next_cal_state = ST_START;
        end
        else
        begin
          next_cal_state = ST_IDLE;
        end
      end
      ST_START:
      begin
        next_cal_state = ST_WAIT;
      end
      ST_WAIT:
      begin
        if (cal_done)
        begin
          next_cal_state = ST_IDLE;
        end
        else
        begin
          next_cal_state = ST_WAIT;
        end
      end
      default:
      begin
        next_cal_state = ST_IDLE;
      end
    endcase
  end

  // ========================================================================
  // Command register and calibration sequencer
  // Holds the command word, settings bits and calibration selection.
  always @(posedge clk_sys)
  begin
    if (!rst_b)
    begin
      task_command_word    <= `TASK_COMMAND_WORD_RST;
      cal_state            <= ST_IDLE;
      line_lock_enable     <= 1'b0;
      die_temp_comp_enable <= 1'b0;
      cal_channel_sel      <= 5'h00;
      cal_offset_mode      <= 1'b0;
    end
    else
    begin
      cal_state <= next_cal_state;
      if (cmd_accepted)
      begin
        // The accepted word is stored and reads back as written.
        task_command_word <= reg_wdata;
        // Every command form carries the line-lock bit.
        line_lock_enable  <= reg_wdata[`CMD_LINE_LOCK_BIT];
        // Calibration words leave compensation as it was.
        if (!is_calibrate)
        begin
          die_temp_comp_enable <= reg_wdata[`CMD_TEMP_COMP_BIT];
        end
        if (is_calibrate)
        begin
          cal_channel_sel <= reg_wdata[`CMD_CAL_SEL_MSB:`CMD_CAL_SEL_LSB];
          cal_offset_mode <= reg_wdata[`CMD_CAL_OFFSET_BIT];
        end
      end
      else if ((cal_state == ST_WAIT) && cal_done)
      begin
        // Finish: opcode cleared and only the kept channel bits remain.
        task_command_word[`CMD_OP_MSB:`CMD_OP_LSB] <= 8'h00;
        task_command_word[`CMD_CAL_SEL_MSB:`CMD_CAL_SEL_LSB] <= cal_keep;
      end
    end
  end

  // ========================================================================
  // Task request pulses
  // Each accepted task raises its request for exactly one cycle.
  always @(posedge clk_sys)
  begin
    if (!rst_b)
    begin
      cal_start           <= 1'b0;
      flash_save_req      <= 1'b0;
      flash_erase_req     <= 1'b0;
      flash_erase_section <= 1'b0;
      soft_reset_req      <= 1'b0;
    end
    else
    begin
      cal_start      <= (cal_state == ST_IDLE) && (next_cal_state == ST_START);
      soft_reset_req <= cmd_accepted && is_soft_reset;
      // Save stores NV defaults and coefficients for use after reset.
      flash_save_req <= cmd_accepted && is_access && (flash_op == `CMD_FLASH_SAVE);
      // Erase names one of two sections; the section line is held after.
      flash_erase_req <= cmd_accepted && is_access &&
                         ((flash_op == `CMD_FLASH_ERASE_SEC0) || (flash_op == `CMD_FLASH_ERASE_SEC1));
      if (cmd_accepted && is_access && (flash_op != `CMD_FLASH_SAVE))
      begin
        flash_erase_section <= flash_op[0];
      end
    end
  end

  // ========================================================================
  // Control register
  // Set bits fire one clear pulse each and then fall back to zero.
  always @(posedge clk_sys)
  begin
    if (!rst_b)
    begin
      accumulator_clear_control <= `ACCUMULATOR_CLEAR_CONTROL_RST;
      energy_accum_clear        <= 1'b0;
      energy_count_clear        <= 1'b0;
      minmax_restart            <= 1'b0;
    end
    else
    begin
      if (wr_ctrl)
      begin
        // Reserved bits are never stored.
        accumulator_clear_control <= reg_wdata & `CTRL_USED_MASK;
      end
      else
      begin
        accumulator_clear_control <= `ACCUMULATOR_CLEAR_CONTROL_RST;
      end
      energy_accum_clear <= wr_ctrl && reg_wdata[`CTRL_CLEAR_ACCUM_BIT];
      energy_count_clear <= wr_ctrl && reg_wdata[`CTRL_CLEAR_COUNT_BIT];
      minmax_restart     <= wr_ctrl && reg_wdata[`CTRL_MINMAX_BIT];
    end
  end

  // ========================================================================
  // Configuration register
  // Bits 21:20 are unused and read as zero.
  always @(posedge clk_sys)
  begin
    if (!rst_b)
    begin
      sensor_routing_config <= `SENSOR_ROUTING_CONFIG_RST;
      zc_ref_select         <= 2'b00;
    end
    else if (wr_cfg)
    begin
      sensor_routing_config <= reg_wdata & `CFG_USED_MASK;
      zc_ref_select         <= reg_wdata[`CFG_REF_MSB:`CFG_REF_LSB];
    end
  end

  // ========================================================================
  // Multiplier decode
  // ========================================================================
  // Ten two-bit fields each become a signed three-bit weight.
  genvar fi;
  generate
    for (fi = 0; fi < `CFG_MULT_FIELDS; fi = fi + 1)
    begin : g_mult
      mult_field_decode u_dec
      (
        .field  (sensor_routing_config[2*fi+1:2*fi]),
        .weight (mult_weights[3*fi+2:3*fi])
      );
    end
  endgenerate

  // ========================================================================
  // Read path
  // ========================================================================
  // Data answers one cycle after the read; unmapped locations read zero.
  always @(posedge clk_sys)
  begin
    if (!rst_b)
    begin
      reg_rdata  <= 24'h000000;
      reg_rvalid <= 1'b0;
    end
    else
    begin
      reg_rvalid <= reg_rd;
      if (reg_rd && addr_ok && (word_index == `TASK_COMMAND_WORD_IDX))
      begin
        reg_rdata <= task_command_word;
      end
      else if (reg_rd && addr_ok && (word_index == `ACCUMULATOR_CLEAR_CONTROL_IDX))
      begin
        reg_rdata <= accumulator_clear_control;
      end
      else if (reg_rd && addr_ok && (word_index == `SENSOR_ROUTING_CONFIG_IDX))
      begin
        reg_rdata <= sensor_routing_config;
      end
      else if (reg_rd)
      begin
        reg_rdata <= 24'h000000;
      end
    end
  end

endmodule // meter_command_control_config

`default_nettype wire

// ### verification/cmd_ctrl_chk.sv
// Concurrent checks on the ports of the command, control and configuration block.
`timescale 1ns/1ps
`default_nettype none

module cmd_ctrl_chk
(
  input wire logic        clk_sys,
  input wire logic        rst_b,
  input wire logic        uart_byte_mode,
  input wire logic        reg_wr,
  input wire logic        reg_rd,
  input wire logic [7:0]  reg_addr,
  input wire logic [23:0] reg_wdata,
  input wire logic        reg_rvalid,
  input wire logic        line_lock_enable,
  input wire logic        die_temp_comp_enable,
  input wire logic        cal_start,
  input wire logic [4:0]  cal_channel_sel,
  input wire logic        cal_offset_mode,
  input wire logic        cal_busy,
  input wire logic        cal_done,
  input wire logic        flash_save_req,
  input wire logic        flash_erase_req,
  input wire logic        flash_erase_section,
  input wire logic        soft_reset_req,
  input wire logic        energy_accum_clear,
  input wire logic        energy_count_clear,
  input wire logic        minmax_restart,
  input wire logic [1:0]  zc_ref_select
);
  // ==========================================================================
  // Decoded host writes.
  wire logic       cmd_wr;  // Command write that the block may accept.
  wire logic       ctl_wr;  // Control register write.
  wire logic       cfg_wr;  // Configuration register write.
  wire logic       acc_wr;  // Command write carrying the flash access code.
  wire logic       bad_wr;  // Command write with no defined code.
  wire logic [7:0] op;      // Top byte of the write data.
  assign op = reg_wdata[23:16];
  assign cmd_wr = reg_wr && !cal_busy && reg_addr == 8'h00;
  assign ctl_wr = reg_wr && reg_addr == (uart_byte_mode ? 8'h6c : 8'h24);
  assign cfg_wr = reg_wr && reg_addr == (uart_byte_mode ? 8'h6f : 8'h25);
  assign acc_wr = cmd_wr && reg_wdata[23:12] == 12'hacc;
  assign bad_wr = cmd_wr && op != 8'h00 && op != 8'hca && op != 8'hbd && !(acc_wr && reg_wdata[11:8] <= 4'h2);

  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (!rst_b);

  // A calibrate command is written, and later the engine reports done.
  sequence s_cal_wr;
    cmd_wr && op == 8'hca;
  endsequence
  sequence s_cal_fin;
    cal_busy && cal_done;
  endsequence

  // ==========================================================================
  // Assertions.
  a_read_answer: assert property (reg_rvalid == $past(reg_rd))
    else $error("read answer not one cycle after the strobe");
  a_cal_launch: assert property (s_cal_wr |=> cal_start && cal_busy &&
    cal_channel_sel == $past(reg_wdata[14:10]) && cal_offset_mode == $past(reg_wdata[9]))
    else $error("calibration launch wrong");
  a_cal_pulse: assert property (cal_start |=> !cal_start)
    else $error("calibration start longer than one cycle");
  a_cal_finish: assert property (s_cal_fin |=> !cal_busy)
    else $error("busy stays after calibration done");
  a_general_set: assert property (cmd_wr && op == 8'h00 |=>
    line_lock_enable == $past(reg_wdata[5]) && die_temp_comp_enable == $past(reg_wdata[4]))
    else $error("general settings not applied");
  a_flash_save: assert property (acc_wr && reg_wdata[11:8] == 4'h2 |=> flash_save_req && !flash_erase_req)
    else $error("flash save request missing");
  a_flash_erase: assert property (acc_wr && reg_wdata[11:9] == 3'h0 |=>
    flash_erase_req && !flash_save_req && flash_erase_section == $past(reg_wdata[8]))
    else $error("flash erase request wrong");
  a_ctrl_pulse: assert property (ctl_wr |=>
    {energy_accum_clear, energy_count_clear, minmax_restart} == $past(reg_wdata[2:0]))
    else $error("control clear pulses wrong");
  a_ref_select: assert property (cfg_wr |=> zc_ref_select == $past(reg_wdata[23:22]))
    else $error("reference select wrong");
  a_soft_reset: assert property (cmd_wr && op == 8'hbd |=> soft_reset_req)
    else $error("software reset request missing");
  a_unknown_cmd: assert property (bad_wr |=>
    !(cal_start || flash_save_req || flash_erase_req || soft_reset_req))
    else $error("undefined command acted upon");
endmodule // cmd_ctrl_chk

bind meter_command_control_config cmd_ctrl_chk cmd_ctrl_chk_inst
(
  .clk_sys, .rst_b, .uart_byte_mode, .reg_wr, .reg_rd, .reg_addr, .reg_wdata, .reg_rvalid,
  .line_lock_enable, .die_temp_comp_enable, .cal_start, .cal_channel_sel, .cal_offset_mode,
  .cal_busy, .cal_done, .flash_save_req, .flash_erase_req, .flash_erase_section, .soft_reset_req,
  .energy_accum_clear, .energy_count_clear, .minmax_restart, .zc_ref_select
);
`default_nettype wire

// ### verification/cal_engine_model.sv
// Behavioural calibration engine that answers the block's calibration handshake.
`timescale 1ns/1ps
`default_nettype none

module cal_engine_model
(
  input  wire logic       clk_sys,
  input  wire logic       rst_b,
  input  wire logic       cal_start,
  input  wire logic [4:0] cal_channel_sel,
  input  wire logic [7:0] reply_delay,
  input  wire logic [4:0] fail_mask,
  output var  logic       cal_done,
  output var  logic [4:0] cal_fail
);
  logic [7:0] wait_count;  // Cycles left before the answer.
  logic       running;     // A calibration is in progress.

  // Counts the chosen delay, then pulses done with the failing channels.
  // Outside the done cycle the fail lines toggle so stale values never pass.
  always @(posedge clk_sys)
  begin
    cal_done <= 1'b0;
    cal_fail <= ~cal_fail;
    if (!rst_b)
    begin
      running  <= 1'b0;
      cal_fail <= 5'h00;
    end
    else if (cal_start)
    begin
      running    <= 1'b1;
      wait_count <= reply_delay;
    end
    else if (running && wait_count == 8'h00)
    begin
      running  <= 1'b0;
      cal_done <= 1'b1;
      cal_fail <= fail_mask & cal_channel_sel;
    end
    else if (running)
      wait_count <= wait_count - 8'h01;
  end
endmodule // cal_engine_model
`default_nettype wire

// ### verification/meter_command_control_config_bench.sv
// Self-checking testbench of the command, control and configuration block.
`timescale 1ns/1ps
`default_nettype none

module meter_command_control_config_bench;
  // ==========================================================================
  // Stimulus and observed signals.
  logic        clk_sys = 1'b0, rst_b = 1'b0, uart_byte_mode = 1'b0, reg_wr = 1'b0, reg_rd = 1'b0;
  logic [7:0]  reg_addr = 8'h00, reply_delay = 8'h04;
  logic [23:0] reg_wdata = 24'h000000, reg_rdata;
  logic [4:0]  fail_mask = 5'h00, cal_channel_sel, cal_fail;
  logic [1:0]  zc_ref_select;
  logic [29:0] mult_weights;
  logic        reg_rvalid, line_lock_enable, die_temp_comp_enable, cal_start, cal_offset_mode;
  logic        cal_busy, cal_done, flash_save_req, flash_erase_req, flash_erase_section;
  logic        soft_reset_req, energy_accum_clear, energy_count_clear, minmax_restart;
  logic [6:0]  pulses;  // All request pulses, calibration start first.
  int          fail_count = 0, checked = 0;
  assign pulses = {cal_start, flash_save_req, flash_erase_req, soft_reset_req,
                   energy_accum_clear, energy_count_clear, minmax_restart};

  // The clock runs at 10 MHz.
  always #50 clk_sys = ~clk_sys;

  meter_command_control_config meter_command_control_config_inst
  (
    .clk_sys, .rst_b, .uart_byte_mode, .reg_wr, .reg_rd, .reg_addr, .reg_wdata, .reg_rdata,
    .reg_rvalid, .line_lock_enable, .die_temp_comp_enable, .cal_start, .cal_channel_sel,
    .cal_offset_mode, .cal_busy, .cal_done, .cal_fail, .flash_save_req, .flash_erase_req,
    .flash_erase_section, .soft_reset_req, .energy_accum_clear, .energy_count_clear,
    .minmax_restart, .zc_ref_select, .mult_weights
  );
  cal_engine_model cal_engine_model_inst
  (
    .clk_sys, .rst_b, .cal_start, .cal_channel_sel, .reply_delay, .fail_mask, .cal_done, .cal_fail
  );

  // ==========================================================================
  // Shared tasks.
  task automatic stop_test();
    if (fail_count == 0 && checked > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask

  task automatic check(input logic [29:0] got, input logic [29:0] exp);
    checked = checked + 1;
    if (got !== exp)
    begin
      fail_count = fail_count + 1;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic do_reset();
    @(posedge clk_sys);
    rst_b <= 1'b0;
    repeat (12) @(posedge clk_sys);
    rst_b <= 1'b1;
    #1;
  endtask

  task automatic set_mode(input logic m);
    @(posedge clk_sys);
    uart_byte_mode <= m;
  endtask

  // One write; returns just after the edge that takes it.
  task automatic wr(input logic [7:0] a, input logic [23:0] d);
    @(posedge clk_sys);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge clk_sys);
    reg_wr <= 1'b0;
    #1;
  endtask

  // One read; the answer must stand in the cycle after the strobe.
  task automatic rd(input logic [7:0] a, input logic [23:0] exp);
    @(posedge clk_sys);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge clk_sys);
    reg_rd <= 1'b0;
    #1;
    check({reg_rvalid, reg_rdata}, {1'b1, exp});
  endtask

  // Waits a bounded time for calibration to end.
  task automatic wait_idle();
    for (int i = 0; i < 300 && cal_busy !== 1'b0; i++)
      @(posedge clk_sys);
    #1;
    if (cal_busy !== 1'b0)
    begin
      fail_count = fail_count + 1;
      stop_test();
    end
  endtask

  // ==========================================================================
  // Scenarios.
  task automatic t_reset();
    do_reset();
    rd(8'h00, 24'h000000);
    rd(8'h24, 24'h000000);
    rd(8'h25, 24'h000000);
    check(mult_weights, 30'h3fffffff);
    check(pulses, 7'h00);
  endtask

  // General settings in both address styles, then a reset in mid-run.
  task automatic t_general();
    wr(8'h00, 24'h000030);
    check({line_lock_enable, die_temp_comp_enable}, 2'b11);
    set_mode(1'b1);
    rd(8'h00, 24'h000030);
    wr(8'h00, 24'h000020);
    check({line_lock_enable, die_temp_comp_enable}, 2'b10);
    do_reset();
    check({line_lock_enable, uart_byte_mode}, 2'b01);
    set_mode(1'b0);
  endtask

  // Gain calibration, one channel failing; busy writes are ignored.
  task automatic t_cal_gain();
    reply_delay = 8'd8;
    fail_mask = 5'h04;
    wr(8'h00, 24'hca7c20);
    check(pulses, 7'h40);
    check({cal_busy, cal_channel_sel, cal_offset_mode, line_lock_enable}, 8'b1_11111_0_1);
    wr(8'h00, 24'h000010);
    check(die_temp_comp_enable, 1'b0);
    wait_idle();
    rd(8'h00, 24'h001020);
  endtask

  // Slow offset calibration keeps its channel bits until the host clears them.
  task automatic t_cal_offset();
    reply_delay = 8'd60;
    fail_mask = 5'h1f;
    wr(8'h00, 24'hca2a20);
    check({cal_channel_sel, cal_offset_mode}, 6'b01010_1);
    wait_idle();
    rd(8'h00, 24'h002a20);
    wr(8'h00, 24'h000000);
    rd(8'h00, 24'h000000);
  endtask

  // Flash erase, save, two undefined codes and the software reset.
  task automatic t_flash();
    for (int k = 0; k < 3; k++)
    begin
      wr(8'h00, {12'hacc, k[3:0], 8'h30});
      check({pulses, flash_erase_section}, {(k == 2) ? 7'h20 : 7'h10, k != 0});
    end
    check({line_lock_enable, die_temp_comp_enable}, 2'b11);
    wr(8'h00, 24'hacc330);
    check(pulses, 7'h00);
    wr(8'h00, 24'h550000);
    check(pulses, 7'h00);
    rd(8'h00, 24'hacc230);
    wr(8'h00, 24'hbd0000);
    check(pulses, 7'h08);
    wr(8'h00, 24'h000000);
  endtask

  // Each control bit alone, through byte addressing; the register self-clears.
  task automatic t_control();
    set_mode(1'b1);
    for (int k = 0; k < 3; k++)
    begin
      wr(8'h6c, 24'h000001 << k);
      check(pulses, 7'h01 << k);
    end
    rd(8'h6c, 24'h000000);
    rd(8'h01, 24'h000000);
    set_mode(1'b0);
  endtask

  // Every reference choice and every multiplier code.
  task automatic t_config();
    for (int r = 0; r < 4; r++)
    begin
      wr(8'h25, {r[1:0], 2'b11, 20'h4e4e4});
      check(zc_ref_select, r[1:0]);
      rd(8'h25, {r[1:0], 2'b00, 20'h4e4e4});
    end
    check(mult_weights, 30'h07447447);
    rd(8'h30, 24'h000000);
    set_mode(1'b1);
    rd(8'h6f, 24'hc4e4e4);
  endtask

  initial
  begin
    t_reset();
    t_general();
    t_cal_gain();
    t_cal_offset();
    t_flash();
    t_control();
    t_config();
    stop_test();
  end
endmodule // meter_command_control_config_bench
`default_nettype wire
